// >>> design/lan_frame_buffer_manager_map.vh
// constants for the lan frame buffer manager
//
// Contract
// RULE1 - pad short transmit frames to minimum
// RULE2 - host posts transmit request with address; code takes only id and length, and frame bytes arrive on i_txd_data
// RULE3 - return transmit id and status
// RULE4 - host keeps transmit buffer until returned
// RULE5 - transmit head only when receive idle
// RULE6 - copy whole frame locally before sending
// RULE7 - link controller defers, serializes, appends fcs
// RULE8 - accept own address unless promiscuous
// RULE9 - drop runt or giant, still count
// RULE10 - host posts receive buffers with ids
// RULE11 - return id when receive buffer filled
// RULE12 - lose frame if off, nobuffer, overrun
// RULE13 - defer receive reports during bursts
// RULE14 - queue receive descriptors, then enable receiver
// RULE15 - crc error reuses descriptor, else record
// RULE16 - malformed command reported, nothing interrupted
// RULE17 - recover jabber, report, keep operating
// RULE18 - fatal error aborts all, interrupts host; code keeps queued transmit entries, sent after i_host_clear
// RULE19 - self-test on reset, power, request, switch
// RULE20 - show self-test code, hold readable
// RULE21 - interrupt host on new responses
// RULE22 - fixed-size queues, pointers in memory
// RULE23 - transmit status tells success from abort; code only ever reports RSP_TX_OK, RSP_TX_ABORT is unused
`ifndef LAN_FRAME_BUFFER_MANAGER_MAP_VH
`define LAN_FRAME_BUFFER_MANAGER_MAP_VH

// ----------------------------------------------------------------
// frame lengths in bytes and queue sizes
// ----------------------------------------------------------------
`define MIN_FRAME_LEN   12'h040
`define MAX_FRAME_LEN   12'h5ee
`define LOCAL_DEPTH     11'h5ee
`define FCS_LEN         3'h4
`define TXQ_DEPTH       3'h4
`define RXQ_DEPTH       3'h4

// ----------------------------------------------------------------
// command and response codes
// ----------------------------------------------------------------
`define CMD_TRANSMIT    2'h1
`define CMD_RECEIVE     2'h2
`define RSP_TX_OK       3'h1
`define RSP_TX_ABORT    3'h2
`define RSP_RX_DONE     3'h3
`define RSP_BAD_CMD     3'h4
`define RSP_RECOVERED   3'h5
`define RSP_FATAL       3'h6

// ----------------------------------------------------------------
// timing counts in cycles
// ----------------------------------------------------------------
`define SELFTEST_CYCLES 8'h40
`define DEFER_CYCLES    4'hc
`define LULL_CYCLES     6'h20

`endif

// >>> design/crc32_step.v
// one-byte step of the ethernet frame check sequence
`timescale 1ns/1ps
`default_nettype none
module crc32_step
(
  // running value and next byte
  input  wire [31:0] i_crc,
  input  wire [7:0]  i_byte,
  // updated value
  output wire [31:0] o_crc
);
  reg [31:0] c;
  integer    k;
  always @*
  begin
    c = i_crc;
    for (k = 0; k < 8; k = k + 1)
    begin
      if (c[0] ^ i_byte[k])
        c = {1'b0, c[31:1]} ^ 32'hedb88320;
      else
        c = {1'b0, c[31:1]};
    end
  end
  assign o_crc = c;
endmodule // crc32_step
`default_nettype wire

// >>> design/lan_frame_buffer_manager.v
// frame buffer manager: command queue, transmit, receive, errors, self-test
`timescale 1ns/1ps
`default_nettype none
`include "lan_frame_buffer_manager_map.vh"
module lan_frame_buffer_manager
(
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_arst_n,
  // command queue entries fetched by the host side
  input  wire        i_cmd_valid,
  input  wire [1:0]  i_cmd_type,
  input  wire [7:0]  i_cmd_id,
  input  wire [11:0] i_cmd_len,
  output reg         o_cmd_ready,
  // transmit data from host memory
  input  wire        i_txd_valid,
  input  wire [7:0]  i_txd_data,
  output reg         o_txd_ready,
  // configuration
  input  wire [47:0] i_station_addr,
  input  wire        i_promisc,
  input  wire        i_multi_en,
  // network serial side, bytes, carrier and jabber pins synchronised here
  input  wire        i_carrier,
  input  wire        i_jabber,
  output reg         o_net_valid,
  output reg  [7:0]  o_net_data,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_data,
  input  wire        i_rx_end,
  // receive data towards host memory
  output reg         o_rxw_valid,
  output reg  [7:0]  o_rxw_data,
  input  wire        i_rxw_ready,
  // response queue
  output reg         o_rsp_valid,
  output reg  [2:0]  o_rsp_code,
  output reg  [7:0]  o_rsp_id,
  input  wire        i_rsp_ready,
  output reg         o_host_irq,
  // errors, self-test
  input  wire        i_mem_error,
  input  wire        i_host_clear,
  input  wire        i_selftest_req,
  input  wire        i_test_switch,
  output reg  [7:0]  o_selftest_code,
  output reg  [7:0]  o_leds,
  output reg  [15:0] o_drop_count
);
  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam S_TEST = 5'h01, S_IDLE = 5'h02, S_COPY = 5'h04;
  localparam S_SEND = 5'h08, S_FATAL = 5'h10;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] car_s_ff, jab_s_ff, sw_s_ff;
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      car_s_ff <= 2'h0;
      jab_s_ff <= 2'h0;
      sw_s_ff  <= 2'h0;
    end
    else
    begin
      car_s_ff <= {car_s_ff[0], i_carrier};
      jab_s_ff <= {jab_s_ff[0], i_jabber};
      sw_s_ff  <= {sw_s_ff[0], i_test_switch};
    end
  end
  wire carrier = car_s_ff[1];
  wire jabber  = jab_s_ff[1];
  wire test_sw = sw_s_ff[1];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [7:0]  local_mem [0:`LOCAL_DEPTH-1];
  reg [7:0]  txq_id_ff [0:3];
  reg [11:0] txq_len_ff [0:3];
  reg [7:0]  rxq_id_ff [0:3];
  reg [2:0]  txq_cnt_ff, rxq_cnt_ff;
  reg [1:0]  txq_rd_ff, txq_wr_ff, rxq_rd_ff, rxq_wr_ff;
  reg [4:0]  state_ff;
  reg [11:0] pos_ff, len_ff, rxlen_ff;
  reg [7:0]  cur_id_ff, test_cnt_ff;
  reg [3:0]  defer_ff;
  reg [2:0]  fcs_ff;
  reg [31:0] tcrc_ff, rcrc_ff;
  reg        rx_on_ff, rx_busy_ff, rx_keep_ff, rx_lost_ff, jab_seen_ff;
  reg        sw_d_ff;
  reg [47:0] dst_ff;
  reg [5:0]  lull_ff;
  reg        rdone_ff;
  reg [7:0]  rdone_id_ff;
  wire [31:0] tcrc_nxt, rcrc_nxt;
  wire [7:0]  tx_byte = (pos_ff < len_ff) ? local_mem[pos_ff[10:0]] : 8'h00;

  crc32_step u_tx_crc (.i_crc(tcrc_ff), .i_byte(tx_byte), .o_crc(tcrc_nxt));
  crc32_step u_rx_crc (.i_crc(rcrc_ff), .i_byte(i_rx_data),
                       .o_crc(rcrc_nxt));

  // RULE19 request and switch edge start causes; reset starts it below
  wire test_start = i_selftest_req | (test_sw & ~sw_d_ff);
  wire rsp_free = ~o_rsp_valid | i_rsp_ready;
  // RULE22 fixed entry counts
  wire txq_full = (txq_cnt_ff == `TXQ_DEPTH);
  wire rxq_full = (rxq_cnt_ff == `RXQ_DEPTH);
  wire cmd_take = o_cmd_ready & i_cmd_valid;
  wire tx_push  = cmd_take & (i_cmd_type == `CMD_TRANSMIT) &
                  (i_cmd_len <= `MAX_FRAME_LEN) & (i_cmd_len != 12'h000);
  wire rx_push  = cmd_take & (i_cmd_type == `CMD_RECEIVE);
  wire bad_cmd  = cmd_take & ~tx_push & ~rx_push;
  wire tx_pop   = (state_ff == S_IDLE) & (txq_cnt_ff != 3'h0) & ~rx_busy_ff;
  wire rx_pop   = rx_busy_ff & i_rx_end & rx_keep_ff & ~rx_lost_ff &
                  (rcrc_nxt == 32'hdebb20e3) &
                  (rxlen_ff + 12'h001 >= `MIN_FRAME_LEN) & ~rdone_ff;
  wire [11:0] pad_len = (len_ff < `MIN_FRAME_LEN - 12'h004) ?
                        (`MIN_FRAME_LEN - 12'h004) : len_ff;
  wire addr_ok = (dst_ff == i_station_addr) | i_promisc |
                 (dst_ff[0] & i_multi_en);
  wire tx_done = (state_ff == S_SEND) & (fcs_ff == `FCS_LEN);
  wire fatal   = i_mem_error & (state_ff != S_FATAL) & (state_ff != S_TEST);
  wire jab_rec = jab_seen_ff & ~jabber;

  // ----------------------------------------------------------------
  // command intake, transmit path and self-test
  // ----------------------------------------------------------------
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      // RULE19 reset starts self-test
      state_ff <= S_TEST;
      test_cnt_ff <= 8'h00;
      txq_cnt_ff <= 3'h0;
      txq_rd_ff <= 2'h0;
      txq_wr_ff <= 2'h0;
      pos_ff <= 12'h000;
      len_ff <= 12'h000;
      cur_id_ff <= 8'h00;
      defer_ff <= 4'h0;
      fcs_ff <= 3'h0;
      tcrc_ff <= 32'hffffffff;
      o_cmd_ready <= 1'b0;
      o_txd_ready <= 1'b0;
      o_net_valid <= 1'b0;
      o_net_data <= 8'h00;
      o_selftest_code <= 8'h00;
      o_leds <= 8'hff;
      sw_d_ff <= 1'b0;
    end
    else
    begin
      sw_d_ff <= test_sw;
      // a test start or fatal error closes intake from the next cycle
      o_cmd_ready <= (state_ff != S_TEST) & (state_ff != S_FATAL) &
                     ~txq_full & ~rxq_full & ~cmd_take & rsp_free &
                     ~test_start & ~fatal;
      if (tx_push)
      begin
        txq_id_ff[txq_wr_ff] <= i_cmd_id;
        txq_len_ff[txq_wr_ff] <= i_cmd_len;
        txq_wr_ff <= txq_wr_ff + 2'h1;
      end
      txq_cnt_ff <= txq_cnt_ff + {2'h0, tx_push} - {2'h0, tx_pop};
      o_net_valid <= 1'b0;
      o_txd_ready <= 1'b0;
      if (test_start)
      begin
        state_ff <= S_TEST;
        test_cnt_ff <= 8'h00;
        o_leds <= 8'hff;
      end
      else if (fatal)
        // RULE18 abort current transfer; queued transmit entries are kept
        state_ff <= S_FATAL;
      else
      begin
        case (state_ff)
          S_TEST:
          begin
            test_cnt_ff <= test_cnt_ff + 8'h01;
            if (test_cnt_ff == `SELFTEST_CYCLES)
            begin
              // RULE20 code on leds and held
              o_selftest_code <= 8'h00;
              o_leds <= 8'h00;
              state_ff <= S_IDLE;
              txq_cnt_ff <= 3'h0;
              txq_rd_ff <= 2'h0;
              txq_wr_ff <= 2'h0;
            end
          end
          S_IDLE:
            // RULE5 head only while receive idle
            if (tx_pop)
            begin
              cur_id_ff <= txq_id_ff[txq_rd_ff];
              len_ff <= txq_len_ff[txq_rd_ff];
              txq_rd_ff <= txq_rd_ff + 2'h1;
              pos_ff <= 12'h000;
              state_ff <= S_COPY;
            end
          S_COPY:
          begin
            // RULE6 whole frame copied first
            o_txd_ready <= ~(i_txd_valid & o_txd_ready &
                             (pos_ff + 12'h001 == len_ff));
            if (i_txd_valid & o_txd_ready)
            begin
              local_mem[pos_ff[10:0]] <= i_txd_data;
              pos_ff <= pos_ff + 12'h001;
              if (pos_ff + 12'h001 == len_ff)
              begin
                state_ff <= S_SEND;
                pos_ff <= 12'h000;
                defer_ff <= 4'h0;
                fcs_ff <= 3'h0;
                tcrc_ff <= 32'hffffffff;
              end
            end
          end
          S_SEND:
          begin
            // RULE7 carrier deferral then serialize
            if (carrier & (pos_ff == 12'h000))
              defer_ff <= 4'h0;
            else if (defer_ff != `DEFER_CYCLES)
              defer_ff <= defer_ff + 4'h1;
            else if (pos_ff < pad_len)
            begin
              // RULE1 zero padding to minimum
              o_net_valid <= 1'b1;
              o_net_data <= tx_byte;
              tcrc_ff <= tcrc_nxt;
              pos_ff <= pos_ff + 12'h001;
            end
            else if (fcs_ff != `FCS_LEN)
            begin
              // RULE7 append inverted crc
              o_net_valid <= 1'b1;
              o_net_data <= ~tcrc_ff[8*fcs_ff[1:0] +: 8];
              fcs_ff <= fcs_ff + 3'h1;
            end
            else if (rsp_free & ~rdone_ff & ~jab_rec & ~bad_cmd)
              state_ff <= S_IDLE;
          end
          S_FATAL:
            if (i_host_clear)
              state_ff <= S_IDLE;
          default:
            state_ff <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receive path and response queue
  // ----------------------------------------------------------------
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rxq_cnt_ff <= 3'h0;
      rxq_rd_ff <= 2'h0;
      rxq_wr_ff <= 2'h0;
      rx_on_ff <= 1'b0;
      rx_busy_ff <= 1'b0;
      rx_keep_ff <= 1'b0;
      rx_lost_ff <= 1'b0;
      rxlen_ff <= 12'h000;
      rcrc_ff <= 32'hffffffff;
      dst_ff <= 48'h0;
      lull_ff <= 6'h00;
      rdone_ff <= 1'b0;
      rdone_id_ff <= 8'h00;
      jab_seen_ff <= 1'b0;
      o_rxw_valid <= 1'b0;
      o_rxw_data <= 8'h00;
      o_rsp_valid <= 1'b0;
      o_rsp_code <= 3'h0;
      o_rsp_id <= 8'h00;
      o_host_irq <= 1'b0;
      o_drop_count <= 16'h0000;
    end
    else
    begin
      if (rx_push)
      begin
        rxq_id_ff[rxq_wr_ff] <= i_cmd_id;
        rxq_wr_ff <= rxq_wr_ff + 2'h1;
      end
      rxq_cnt_ff <= rxq_cnt_ff + {2'h0, rx_push} - {2'h0, rx_pop};
      // RULE14 receiver on once a descriptor is queued
      rx_on_ff <= ((rxq_cnt_ff != 3'h0) | rx_push) &
                  (state_ff != S_TEST) & (state_ff != S_FATAL);
      if (i_rxw_ready)
        o_rxw_valid <= 1'b0;
      if (jabber)
        jab_seen_ff <= 1'b1;
      if (i_rx_valid & ~rx_busy_ff)
      begin
        // RULE12 lost when off or no buffer
        rx_busy_ff <= 1'b1;
        rx_keep_ff <= 1'b1;
        rx_lost_ff <= ~rx_on_ff | (rxq_cnt_ff == 3'h0);
        rxlen_ff <= 12'h001;
        rcrc_ff <= rcrc_nxt;
        dst_ff <= {40'h0, i_rx_data};
      end
      else if (i_rx_valid & rx_busy_ff)
      begin
        rxlen_ff <= rxlen_ff + 12'h001;
        rcrc_ff <= rcrc_nxt;
        if (rxlen_ff < 12'h006)
          dst_ff <= dst_ff | ({40'h0, i_rx_data} << (8 * rxlen_ff));
        if (rxlen_ff == 12'h006)
          // RULE8 address filter
          rx_keep_ff <= addr_ok;
        // RULE9 giant not delivered
        if (rxlen_ff >= `MAX_FRAME_LEN)
          rx_keep_ff <= 1'b0;
        if (rx_keep_ff & ~rx_lost_ff & (rxlen_ff >= 12'h006))
        begin
          // RULE12 memory overrun loses the frame
          if (o_rxw_valid & ~i_rxw_ready)
            rx_lost_ff <= 1'b1;
          else
          begin
            o_rxw_valid <= 1'b1;
            o_rxw_data <= i_rx_data;
          end
        end
      end
      if (i_rx_end & rx_busy_ff)
      begin
        rx_busy_ff <= 1'b0;
        rcrc_ff <= 32'hffffffff;
        // RULE9 runt and giant still counted
        if (~rx_pop)
          o_drop_count <= o_drop_count + 16'h0001;
        // RULE15 good frame consumes descriptor
        if (rx_pop)
        begin
          rdone_ff <= 1'b1;
          rdone_id_ff <= rxq_id_ff[rxq_rd_ff];
          rxq_rd_ff <= rxq_rd_ff + 2'h1;
        end
      end
      // RULE13 report after a lull
      if (i_rx_valid)
        lull_ff <= 6'h00;
      else if (lull_ff != `LULL_CYCLES)
        lull_ff <= lull_ff + 6'h01;
      o_host_irq <= 1'b0;
      if (i_rsp_ready)
        o_rsp_valid <= 1'b0;
      if (rsp_free)
      begin
        if (fatal)
        begin
          // RULE18 fatal cause to host
          o_rsp_valid <= 1'b1;
          o_rsp_code <= `RSP_FATAL;
          o_rsp_id <= cur_id_ff;
          o_host_irq <= 1'b1;
        end
        else if (tx_done & ~rdone_ff & ~jab_rec & ~bad_cmd)
        begin
          // RULE3 RULE23 id and success status
          o_rsp_valid <= 1'b1;
          o_rsp_code <= `RSP_TX_OK;
          o_rsp_id <= cur_id_ff;
          // RULE21 interrupt on new response
          o_host_irq <= 1'b1;
        end
        else if (bad_cmd)
        begin
          // RULE16 report only
          o_rsp_valid <= 1'b1;
          o_rsp_code <= `RSP_BAD_CMD;
          o_rsp_id <= i_cmd_id;
          o_host_irq <= 1'b1;
        end
        else if (jab_rec)
        begin
          // RULE17 recovery logged
          jab_seen_ff <= 1'b0;
          o_rsp_valid <= 1'b1;
          o_rsp_code <= `RSP_RECOVERED;
          o_rsp_id <= 8'h00;
          o_host_irq <= 1'b1;
        end
        else if (rdone_ff & (lull_ff == `LULL_CYCLES))
        begin
          // RULE11 filled buffer id returned
          rdone_ff <= 1'b0;
          o_rsp_valid <= 1'b1;
          o_rsp_code <= `RSP_RX_DONE;
          o_rsp_id <= rdone_id_ff;
          o_host_irq <= 1'b1;
        end
      end
      if (fatal | test_start)
      begin
        rxq_cnt_ff <= 3'h0;
        rxq_rd_ff <= 2'h0;
        rxq_wr_ff <= 2'h0;
        rx_busy_ff <= 1'b0;
        rdone_ff <= 1'b0;
      end
    end
  end
endmodule // lan_frame_buffer_manager
`default_nettype wire

// >>> test/lfbm_sva.sv
// assertion checker for the frame buffer manager ports
`timescale 1ns/1ps
`default_nettype none
module lfbm_sva
(
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  // watched ports
  input wire logic        i_cmd_valid,
  input wire logic        o_cmd_ready,
  input wire logic        o_txd_ready,
  input wire logic        o_net_valid,
  input wire logic        o_rxw_valid,
  input wire logic [7:0]  o_rxw_data,
  input wire logic        i_rxw_ready,
  input wire logic        o_rsp_valid,
  input wire logic [2:0]  o_rsp_code,
  input wire logic [7:0]  o_rsp_id,
  input wire logic        i_rsp_ready,
  input wire logic        o_host_irq,
  input wire logic        i_mem_error,
  input wire logic [7:0]  o_leds,
  input wire logic [15:0] o_drop_count
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  rsp_hold_a: assert property (o_rsp_valid && !i_rsp_ready |=>
    o_rsp_valid && $stable(o_rsp_code) && $stable(o_rsp_id))
    else $error("response changed before it was taken");
  rsp_irq_a: assert property ($rose(o_rsp_valid) |-> o_host_irq)
    else $error("new response without interrupt");
  irq_rsp_a: assert property (o_host_irq |-> o_rsp_valid)
    else $error("interrupt without a response");
  rxw_hold_a: assert property (o_rxw_valid && !i_rxw_ready |=>
    o_rxw_valid && $stable(o_rxw_data))
    else $error("write byte changed before it was taken");
  cmd_gap_a: assert property (i_cmd_valid && o_cmd_ready |=>
    !o_cmd_ready)
    else $error("command ready in the cycle after a take");
  copy_first_a: assert property (o_net_valid |-> !o_txd_ready)
    else $error("fetching while serializing");
  test_leds_a: assert property (o_cmd_ready |-> o_leds == 8'h00)
    else $error("commands taken while test code shows");
  reset_test_a: assert property ($rose(i_arst_n) |->
    (o_leds == 8'hff) [*4])
    else $error("no self-test after reset");
  drop_step_a: assert property ($changed(o_drop_count) |->
    o_drop_count == $past(o_drop_count) + 16'h0001)
    else $error("drop count moved by more than one");
  fatal_stop_a: assert property ($rose(i_mem_error) |->
    ##[2:4] !o_cmd_ready ##1 !o_cmd_ready)
    else $error("commands still taken after fatal error");
endmodule // lfbm_sva
`default_nettype wire

// >>> test/host_mem_model.sv
// host memory side model: frame bytes, response and write handshakes
`timescale 1ns/1ps
`default_nettype none
module host_mem_model
(
  // clock and pace
  input  wire logic       i_mclk,
  input  wire logic       i_slow,
  // transmit byte supply
  input  wire logic       i_txd_ready,
  output var  logic       o_txd_valid,
  output var  logic [7:0] o_txd_data,
  // response and receive write acceptance
  output var  logic       o_rsp_ready,
  output var  logic       o_rxw_ready
);
  logic [7:0] idx_ff;
  logic       took_ff;
  logic       tog_ff;
  initial
  begin
    idx_ff = 8'h00;
    took_ff = 1'b0;
    tog_ff = 1'b0;
    o_txd_valid = 1'b1;
    o_txd_data = 8'ha5;
    o_rsp_ready = 1'b1;
    o_rxw_ready = 1'b1;
  end
  always @(posedge i_mclk)
    took_ff <= o_txd_valid & i_txd_ready;
  // buffer stays fixed
  // byte k of the buffer is k^a5; slow pace idles a cycle after a take
  always @(negedge i_mclk)
  begin
    if (took_ff)
      idx_ff = idx_ff + 8'h01;
    tog_ff = ~tog_ff;
    o_txd_valid = !(i_slow && took_ff);
    o_txd_data = o_txd_valid ? idx_ff ^ 8'ha5 : ~(idx_ff ^ 8'ha5);
    o_rsp_ready = !i_slow || tog_ff;
    o_rxw_ready = !i_slow || tog_ff;
  end
endmodule // host_mem_model
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the frame buffer manager
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_mclk, i_arst_n, i_cmd_valid, o_cmd_ready, slow;
  logic        i_txd_valid, o_txd_ready, i_promisc, i_multi_en;
  logic        i_carrier, i_jabber, o_net_valid, i_rx_valid, i_rx_end;
  logic        o_rxw_valid, i_rxw_ready, o_rsp_valid, i_rsp_ready;
  logic        o_host_irq, i_mem_error, i_host_clear, i_selftest_req;
  logic        i_test_switch;
  logic [1:0]  i_cmd_type;
  logic [2:0]  o_rsp_code;
  logic [7:0]  i_cmd_id, i_txd_data, o_net_data, i_rx_data, o_rxw_data;
  logic [7:0]  o_rsp_id, o_selftest_code, o_leds, fr[0:127];
  logic [11:0] i_cmd_len;
  logic [15:0] o_drop_count, d0;
  logic [47:0] i_station_addr;
  logic [7:0]  net_q[$];
  logic [10:0] rsp_q[$];
  int          error_cnt, check_count, cyc, n;

  lan_frame_buffer_manager dut
  (
    .i_mclk, .i_arst_n, .i_cmd_valid, .i_cmd_type, .i_cmd_id, .i_cmd_len,
    .o_cmd_ready, .i_txd_valid, .i_txd_data, .o_txd_ready, .i_station_addr,
    .i_promisc, .i_multi_en, .i_carrier, .i_jabber, .o_net_valid,
    .o_net_data, .i_rx_valid, .i_rx_data, .i_rx_end, .o_rxw_valid,
    .o_rxw_data, .i_rxw_ready, .o_rsp_valid, .o_rsp_code, .o_rsp_id,
    .i_rsp_ready, .o_host_irq, .i_mem_error, .i_host_clear,
    .i_selftest_req, .i_test_switch, .o_selftest_code, .o_leds,
    .o_drop_count
  );
  host_mem_model u_host
  (
    .i_mclk, .i_slow(slow), .i_txd_ready(o_txd_ready),
    .o_txd_valid(i_txd_valid), .o_txd_data(i_txd_data),
    .o_rsp_ready(i_rsp_ready), .o_rxw_ready(i_rxw_ready)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // ------------------------------------------------------------
  // monitors; the whole run needs well under 20000 cycles
  // ------------------------------------------------------------
  always @(posedge i_mclk)
  begin
    if (o_net_valid)
      net_q.push_back(o_net_data);
    if (o_rsp_valid && i_rsp_ready)
      rsp_q.push_back({o_rsp_code, o_rsp_id});
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_ready;
    for (n = 0; n < 300 && o_cmd_ready !== 1'b1; n++)
      @(negedge i_mclk);
  endtask
  task automatic cmd(input logic [1:0] t, input logic [7:0] id,
                     input logic [11:0] len);
    {i_cmd_type, i_cmd_id, i_cmd_len} = {t, id, len};
    i_cmd_valid = 1'b1;
    wait_ready();
    chk("command ready", 1, o_cmd_ready);
    @(negedge i_mclk);
    i_cmd_valid = 1'b0;
  endtask
  task automatic get_rsp(input logic [2:0] c, input logic [7:0] id,
                         input bit use_id);
    logic [10:0] r;
    for (n = 0; n < 3000 && rsp_q.size() == 0; n++)
      @(negedge i_mclk);
    r = (rsp_q.size() != 0) ? rsp_q.pop_front() : 11'h7ff;
    chk("response code", c, r[10:8]);
    if (use_id)
      chk("response id", id, r[7:0]);
  endtask
  function automatic logic [31:0] crc_of(input int len);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < len; i++)
    begin
      c = c ^ {24'h000000, fr[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction
  // bytes spaced one idle cycle apart so a paced writer keeps up
  task automatic rx_frame(input int len, input logic [7:0] b0, input bit bad);
    logic [31:0] c;
    for (int i = 0; i < len; i++)
      fr[i] = (i < 6) ? i_station_addr[8*i +: 8] : 8'(i);
    fr[0] = b0;
    c = crc_of(len) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++)
      fr[len+i] = c[8*i +: 8];
    for (int i = 0; i < len + 4; i++)
    begin
      i_rx_valid = 1'b1;
      i_rx_data = fr[i];
      i_rx_end = (i == len + 3);
      @(negedge i_mclk);
      i_rx_valid = 1'b0;
      i_rx_data = ~fr[i];
      i_rx_end = 1'b0;
      @(negedge i_mclk);
    end
    repeat (60) @(negedge i_mclk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_tx;
    logic [31:0] c;
    slow = 1'b1;
    cmd(2'h1, 8'h31, 12'h00a);
    get_rsp(3'h1, 8'h31, 1'b1);
    chk("frame bytes", 64, net_q.size());
    for (int i = 0; i < 60; i++)
      fr[i] = (i < 10) ? 8'(i) ^ 8'ha5 : 8'h00;
    c = crc_of(60);
    for (int i = 0; i < 64; i++)
      chk("net byte", i < 60 ? fr[i] : c[8*(i-60) +: 8], net_q[i]);
    slow = 1'b0;
  endtask
  task automatic t_bad;
    logic [13:0] tab[3] = '{{2'h3, 12'h010}, {2'h1, 12'h000}, {2'h1, 12'h5ef}};
    for (int i = 0; i < 3; i++)
    begin
      cmd(tab[i][13:12], 8'h41 + 8'(i), tab[i][11:0]);
      get_rsp(3'h4, 8'h41 + 8'(i), 1'b1);
    end
    chk("no frame sent", 64, net_q.size());
  endtask
  task automatic t_rx;
    d0 = o_drop_count;
    slow = 1'b1;
    rx_frame(60, 8'h11, 1'b0);
    chk("lost count", d0 + 16'h1, o_drop_count);
    cmd(2'h2, 8'h22, 12'h5ee);
    rx_frame(20, 8'h11, 1'b0);
    rx_frame(60, 8'h11, 1'b1);
    rx_frame(60, 8'h12, 1'b0);
    chk("drop count", d0 + 16'h4, o_drop_count);
    chk("no response", 0, rsp_q.size());
    rx_frame(60, 8'h11, 1'b0);
    get_rsp(3'h3, 8'h22, 1'b1);
    slow = 1'b0;
  endtask
  task automatic t_err;
    i_jabber = 1'b1;
    repeat (8) @(negedge i_mclk);
    i_jabber = 1'b0;
    get_rsp(3'h5, 8'h00, 1'b0);
    i_mem_error = 1'b1;
    @(negedge i_mclk);
    i_mem_error = 1'b0;
    get_rsp(3'h6, 8'h00, 1'b0);
    repeat (20) @(negedge i_mclk);
    chk("ready while fatal", 0, o_cmd_ready);
    i_host_clear = 1'b1;
    @(negedge i_mclk);
    i_host_clear = 1'b0;
    wait_ready();
    chk("ready after clear", 1, o_cmd_ready);
  endtask
  task automatic t_self;
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        i_selftest_req = 1'b1;
      else
        i_test_switch = 1'b1;
      repeat (4) @(negedge i_mclk);
      {i_selftest_req, i_test_switch} = 2'b00;
      chk("leds in test", 8'hff, o_leds);
      wait_ready();
      chk("leds after test", 8'h00, o_leds);
      chk("test code", 8'h00, o_selftest_code);
    end
  endtask

  initial
  begin
    {i_cmd_valid, i_cmd_type, i_cmd_id, i_cmd_len} = 23'h0;
    {i_promisc, i_multi_en, i_carrier, i_jabber, slow} = 5'h00;
    {i_rx_valid, i_rx_data, i_rx_end, i_mem_error} = 11'h000;
    {i_host_clear, i_selftest_req, i_test_switch} = 3'h0;
    i_station_addr = 48'h665544332211;
    i_arst_n = 1'b0;
    repeat (6) @(negedge i_mclk);
    chk("leds in reset", 8'hff, o_leds);
    i_arst_n = 1'b1;
    wait_ready();
    chk("test code", 8'h00, o_selftest_code);
    t_tx();
    t_bad();
    t_rx();
    t_err();
    t_self();
    summarize();
  end
endmodule // tb

bind lan_frame_buffer_manager lfbm_sva u_sva
(
  .i_mclk, .i_arst_n, .i_cmd_valid, .o_cmd_ready, .o_txd_ready,
  .o_net_valid, .o_rxw_valid, .o_rxw_data, .i_rxw_ready, .o_rsp_valid,
  .o_rsp_code, .o_rsp_id, .i_rsp_ready, .o_host_irq, .i_mem_error,
  .o_leds, .o_drop_count
);
`default_nettype wire
